// ---- bench/host_model.sv ----
/*
 * Host-side model of the control bus: single-byte register writes and
 * main or extended page reads. Assumes strobes sampled on ref_clk.
 */
`timescale 1ns/1ps
module host_model
(
    input  wire logic       ref_clk,
    output logic            regWrite,
    output logic            regRead,
    output logic [7:0]      regAddr,
    output logic [7:0]      regWriteData,
    input  wire logic [7:0] regReadData,
    input  wire logic       regReadValid,
    output logic            extRead,
    output logic [7:0]      extAddr
);
    initial
    begin
        regWrite = 1'b0;
        regRead = 1'b0;
        extRead = 1'b0;
        regAddr = 8'h00;
        extAddr = 8'h00;
        regWriteData = 8'h00;
    end

    // callers keep set-point codes above 001100
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWriteData <= d;
        @(posedge ref_clk);
        regWrite <= 1'b0;
        // stale bus value would hide a late sample
        regAddr <= ~a;
        regWriteData <= ~d;
    endtask

    task automatic read_reg(input logic [7:0] a, input logic ext, output logic [7:0] d);
        @(posedge ref_clk);
        regRead <= !ext;
        extRead <= ext;
        regAddr <= a;
        extAddr <= a;
        @(posedge ref_clk);
        regRead <= 1'b0;
        extRead <= 1'b0;
        regAddr <= ~a;
        extAddr <= ~a;
        @(negedge ref_clk);
        d = regReadValid ? regReadData : 8'hXX;
    endtask
endmodule

// ---- bench/tb_buck_setpoint_register_bank.sv ----
/*
 * Self-checking bench for the buck set-point register bank.
 * Assumes a 40 MHz ref_clk and the host model for bus traffic.
 */
`timescale 1ns/1ps
module tb_buck_setpoint_register_bank;
    logic       ref_clk, rst, regWrite, regRead, extRead, otpLoad, standby, sleepMode;
    logic [7:0] regAddr, regWriteData, regReadData, extAddr, modeSelect;
    logic       regReadValid, rampBusy, phaseConfigValid;
    logic [1:0] otpPhaseConfig;
    logic [5:0] setpointCode, targetCode;
    buck_setpoint_pkg::shared_config_t switchNodeA, switchNodeB;
    int         mismatches = 0;
    int         testsRun = 0;

    buck_setpoint_register_bank i_dut (.ref_clk(ref_clk), .rst(rst), .regWrite(regWrite),
        .regRead(regRead), .regAddr(regAddr), .regWriteData(regWriteData),
        .regReadData(regReadData), .regReadValid(regReadValid), .extRead(extRead),
        .extAddr(extAddr), .otpLoad(otpLoad), .otpPhaseConfig(otpPhaseConfig),
        .standby(standby), .sleepMode(sleepMode), .setpointCode(setpointCode),
        .targetCode(targetCode), .rampBusy(rampBusy), .switchNodeA(switchNodeA),
        .switchNodeB(switchNodeB), .modeSelect(modeSelect),
        .phaseConfigValid(phaseConfigValid));
    host_model i_host (.ref_clk(ref_clk), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regWriteData(regWriteData), .regReadData(regReadData),
        .regReadValid(regReadValid), .extRead(extRead), .extAddr(extAddr));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
        testsRun++;
        if (seen !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
            mismatches++;
        end
    endtask

    task automatic reg_is(input logic [7:0] a, input logic ext, input logic [7:0] exp);
        logic [7:0] d;
        i_host.read_reg(a, ext, d);
        check($sformatf("reg %h", a), {8'h00, exp}, {8'h00, d});
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", testsRun, mismatches);
        if (mismatches == 0 && testsRun > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic test_reset_map();
        logic [7:0] exp [6] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00};
        for (int i = 0; i < 6; i++)
            reg_is(8'h20 + 8'(i), 1'b0, exp[i]);
        check("phase valid", 16'h0001, {15'h0000, phaseConfigValid});
        check("mode reset", 16'h0080, {8'h00, modeSelect});
    endtask

    task automatic test_points();
        i_host.write_reg(8'h20, 8'hFF);
        i_host.write_reg(8'h21, 8'hD1);
        i_host.write_reg(8'h22, 8'hCE);
        i_host.write_reg(8'h25, 8'h5A);
        i_host.write_reg(8'h23, 8'hFF);
        reg_is(8'h20, 1'b0, 8'h3F);
        reg_is(8'h21, 1'b0, 8'h11);
        reg_is(8'h22, 1'b0, 8'h0E);
        reg_is(8'h25, 1'b0, 8'h00);
        reg_is(8'h23, 1'b0, 8'h2F);
        check("mode out", 16'h002F, {8'h00, modeSelect});
    endtask

    task automatic test_modes();
        settle(2);
        check("normal sel", 16'h003F, {10'h000, setpointCode});
        @(posedge ref_clk);
        standby <= 1'b1;
        settle(2);
        check("standby sel", 16'h0011, {10'h000, setpointCode});
        i_host.write_reg(8'h20, 8'h30);
        reg_is(8'h20, 1'b0, 8'h30);
        settle(2);
        check("held normal", 16'h0011, {10'h000, setpointCode});
        @(posedge ref_clk);
        sleepMode <= 1'b1;
        settle(2);
        check("sleep sel", 16'h000E, {10'h000, setpointCode});
        @(posedge ref_clk);
        sleepMode <= 1'b0;
        standby <= 1'b0;
        settle(2);
        check("back normal", 16'h0030, {10'h000, setpointCode});
    endtask

    task automatic test_config();
        i_host.write_reg(8'h24, 8'hD5);
        reg_is(8'h24, 1'b0, 8'hD5);
        check("node a", 16'h0057, {9'h000, switchNodeA});
        check("node b", 16'h0057, {9'h000, switchNodeB});
    endtask

    task automatic test_ramp();
        int n;
        logic [5:0] last;
        for (int s = 0; s < 4; s++)
        begin
            i_host.write_reg(8'h24, {2'(s), 6'h00});
            i_host.write_reg(8'h20, 8'h20);
            n = 0;
            settle(3);
            while (rampBusy !== 1'b0 && n < 8000)
            begin
                settle(0);
                n++;
            end
            check("ramp settle", 16'h0020, {10'h000, targetCode});
            i_host.write_reg(8'h20, 8'h22);
            last = targetCode;
            for (n = 0; targetCode === last && n < 2000; n++)
                settle(0);
            last = targetCode;
            for (n = 0; targetCode === last && n < 2000; n++)
                settle(0);
            check("step gap", 16'(80 << s), 16'(n));
            check("step size", 16'h0022, {10'h000, targetCode});
        end
    endtask

    // a reserved code first, then the single-phase code
    task automatic test_otp();
        for (int k = 0; k < 2; k++)
        begin
            @(posedge ref_clk);
            otpPhaseConfig <= (k != 0) ? 2'h1 : 2'h2;
            otpLoad <= 1'b1;
            @(posedge ref_clk);
            otpLoad <= 1'b0;
            reg_is(8'h00, 1'b1, (k != 0) ? 8'h01 : 8'h02);
            check("phase ok", 16'(k), {15'h0000, phaseConfigValid});
        end
    endtask

    // ------------------------------------------------------------
    // clock, reset, sequence, watchdog
    // ------------------------------------------------------------
    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    initial
    begin
        rst = 1'b1;
        standby = 1'b0;
        sleepMode = 1'b0;
        otpLoad = 1'b0;
        otpPhaseConfig = 2'h0;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        test_reset_map();
        test_points();
        test_modes();
        test_config();
        test_ramp();
        test_otp();
        tally_and_finish();
    end

    // about 7k cycles expected; margin for a slow ramp
    initial
    begin
        repeat (60000) @(posedge ref_clk);
        mismatches++;
        tally_and_finish();
    end
endmodule

// ---- common/buck_setpoint_pkg.sv ----
/*
 * Package for the buck set-point register bank: register offsets, field
 * positions, reset values, the active-mode enum and the ramp timing.
 * Assumes a single 40 MHz system clock.
 */
package buck_setpoint_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] NORMAL_SETPOINT_ADDR  = 8'h20;
    localparam logic [7:0] STANDBY_SETPOINT_ADDR = 8'h21;
    localparam logic [7:0] SLEEP_SETPOINT_ADDR   = 8'h22;
    localparam logic [7:0] MODE_SELECT_ADDR      = 8'h23;
    localparam logic [7:0] SHARED_CONFIG_ADDR    = 8'h24;
    // extended page address of the phase configuration field
    localparam logic [7:0] PHASE_CONFIG_ADDR     = 8'h00;

    localparam logic [7:0] SETPOINT_RESET        = 8'h00;
    localparam logic [7:0] MODE_SELECT_RESET     = 8'h80;
    localparam logic [7:0] SHARED_CONFIG_RESET   = 8'h00;
    localparam logic [7:0] SETPOINT_MASK         = 8'h3F;
    localparam logic [7:0] MODE_SELECT_MASK      = 8'h2F;

    // ------------------------------------------------------------
    // fields
    // ------------------------------------------------------------
    localparam int          CODE_WIDTH          = 6;
    localparam int          ILIM_BIT            = 0;
    localparam int          FREQ_LSB            = 2;
    localparam int          PHASE_LSB           = 4;
    localparam int          SPEED_LSB           = 6;
    localparam logic [1:0]  PHASE_CONFIG_SINGLE = 2'h1;

    // ------------------------------------------------------------
    // timing: one 25 mV step each 2 us at speed code 0, doubling per code
    // ------------------------------------------------------------
    localparam int          CLOCK_MHZ           = 40;
    localparam int          STEP_BASE_US        = 2;
    localparam int          STEP_BASE_CYCLES    = STEP_BASE_US * CLOCK_MHZ;
    localparam int          STEP_COUNT_WIDTH    = 11;

    typedef enum logic [1:0] {
        MODE_NORMAL  = 2'b00,
        MODE_STANDBY = 2'b01,
        MODE_SLEEP   = 2'b10
    } active_mode_t;

    typedef struct packed {
        logic       currentLimitLevel;
        logic [1:0] switchingFreqSelect;
        logic [1:0] clockPhaseSelect;
        logic [1:0] rampSpeedSelect;
    } shared_config_t;

endpackage

// ---- rtl/buck_setpoint_register_bank.sv ----
/*
 * Set-point and configuration register bank for one single-phase buck
 * channel, with the mode selection and the ramp toward the chosen code.
 * Assumes the control-bus slave outside delivers single-cycle byte
 * read and write strobes, synchronous to ref_clk.
 */
`timescale 1ns/1ps
module buck_setpoint_register_bank
(
    input  wire logic                                      ref_clk,
    input  wire logic                                      rst,
    // control-bus side, main page
    input  wire logic                                      regWrite,
    input  wire logic                                      regRead,
    input  wire logic [7:0]                                regAddr,
    input  wire logic [7:0]                                regWriteData,
    output logic      [7:0]                                regReadData,
    output logic                                           regReadValid,
    // extended page and OTP
    input  wire logic                                      extRead,
    input  wire logic [7:0]                                extAddr,
    input  wire logic                                      otpLoad,
    input  wire logic [1:0]                                otpPhaseConfig,
    // power mode inputs
    input  wire logic                                      standby,
    input  wire logic                                      sleepMode,
    // toward the regulator
    output logic      [buck_setpoint_pkg::CODE_WIDTH-1:0]  setpointCode,
    output logic      [buck_setpoint_pkg::CODE_WIDTH-1:0]  targetCode,
    output logic                                           rampBusy,
    output buck_setpoint_pkg::shared_config_t              switchNodeA,
    output buck_setpoint_pkg::shared_config_t              switchNodeB,
    output logic      [7:0]                                modeSelect,
    output logic                                           phaseConfigValid
);

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [7:0]                           normalSetpointReg;
    logic [7:0]                           standbySetpointReg;
    logic [7:0]                           sleepSetpointReg;
    logic [7:0]                           modeSelectReg;
    logic [7:0]                           sharedConfigReg;
    logic [1:0]                           phaseConfigField;
    logic [7:0]                           next_normalSetpointReg;
    logic [7:0]                           next_standbySetpointReg;
    logic [7:0]                           next_sleepSetpointReg;
    logic [7:0]                           next_modeSelectReg;
    logic [7:0]                           next_sharedConfigReg;
    logic [1:0]                           next_phaseConfigField;
    logic [7:0]                           next_regReadData;
    logic                                 next_regReadValid;

    always_comb
    begin
        next_normalSetpointReg  = normalSetpointReg;
        next_standbySetpointReg = standbySetpointReg;
        next_sleepSetpointReg   = sleepSetpointReg;
        next_modeSelectReg      = modeSelectReg;
        next_sharedConfigReg    = sharedConfigReg;
        next_phaseConfigField   = phaseConfigField;
        next_regReadData        = 8'h00;
        next_regReadValid       = 1'b0;
        // otp is the only writer of the phase configuration field
        if (otpLoad)
            next_phaseConfigField = otpPhaseConfig;
        if (regWrite)
        begin
            unique case (regAddr)
                buck_setpoint_pkg::NORMAL_SETPOINT_ADDR:
                    next_normalSetpointReg = regWriteData & buck_setpoint_pkg::SETPOINT_MASK;
                buck_setpoint_pkg::STANDBY_SETPOINT_ADDR:
                    next_standbySetpointReg = regWriteData & buck_setpoint_pkg::SETPOINT_MASK;
                buck_setpoint_pkg::SLEEP_SETPOINT_ADDR:
                    next_sleepSetpointReg = regWriteData & buck_setpoint_pkg::SETPOINT_MASK;
                buck_setpoint_pkg::MODE_SELECT_ADDR:
                    next_modeSelectReg = regWriteData & buck_setpoint_pkg::MODE_SELECT_MASK;
                buck_setpoint_pkg::SHARED_CONFIG_ADDR:
                    next_sharedConfigReg = regWriteData;
                default:
                    next_sharedConfigReg = sharedConfigReg;
            endcase
        end
        if (regRead)
        begin
            next_regReadValid = 1'b1;
            unique case (regAddr)
                buck_setpoint_pkg::NORMAL_SETPOINT_ADDR:  next_regReadData = normalSetpointReg;
                buck_setpoint_pkg::STANDBY_SETPOINT_ADDR: next_regReadData = standbySetpointReg;
                buck_setpoint_pkg::SLEEP_SETPOINT_ADDR:   next_regReadData = sleepSetpointReg;
                buck_setpoint_pkg::MODE_SELECT_ADDR:      next_regReadData = modeSelectReg;
                buck_setpoint_pkg::SHARED_CONFIG_ADDR:    next_regReadData = sharedConfigReg;
                default:                                  next_regReadData = 8'h00;
            endcase
        end
        else if (extRead)
        begin
            // phase configuration is visible only on the extended page
            next_regReadValid = 1'b1;
            if (extAddr == buck_setpoint_pkg::PHASE_CONFIG_ADDR)
                next_regReadData = {6'h00, phaseConfigField};
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            normalSetpointReg  <= buck_setpoint_pkg::SETPOINT_RESET;
            standbySetpointReg <= buck_setpoint_pkg::SETPOINT_RESET;
            sleepSetpointReg   <= buck_setpoint_pkg::SETPOINT_RESET;
            modeSelectReg      <= buck_setpoint_pkg::MODE_SELECT_RESET;
            sharedConfigReg    <= buck_setpoint_pkg::SHARED_CONFIG_RESET;
            phaseConfigField   <= buck_setpoint_pkg::PHASE_CONFIG_SINGLE;
            regReadData        <= 8'h00;
            regReadValid       <= 1'b0;
        end
        else
        begin
            normalSetpointReg  <= next_normalSetpointReg;
            standbySetpointReg <= next_standbySetpointReg;
            sleepSetpointReg   <= next_sleepSetpointReg;
            modeSelectReg      <= next_modeSelectReg;
            sharedConfigReg    <= next_sharedConfigReg;
            phaseConfigField   <= next_phaseConfigField;
            regReadData        <= next_regReadData;
            regReadValid       <= next_regReadValid;
        end
    end

    // ------------------------------------------------------------
    // mode selection and drive toward the regulator
    // ------------------------------------------------------------
    buck_setpoint_pkg::active_mode_t       activeMode;
    buck_setpoint_pkg::shared_config_t     sharedFields;
    logic [buck_setpoint_pkg::CODE_WIDTH-1:0] next_setpointCode;
    logic                                  next_phaseConfigValid;

    always_comb
    begin
        // sleep outranks standby
        if (sleepMode)
            activeMode = buck_setpoint_pkg::MODE_SLEEP;
        else if (standby)
            activeMode = buck_setpoint_pkg::MODE_STANDBY;
        else
            activeMode = buck_setpoint_pkg::MODE_NORMAL;
        unique case (activeMode)
            buck_setpoint_pkg::MODE_NORMAL:
                next_setpointCode = normalSetpointReg[buck_setpoint_pkg::CODE_WIDTH-1:0];
            buck_setpoint_pkg::MODE_STANDBY:
                next_setpointCode = standbySetpointReg[buck_setpoint_pkg::CODE_WIDTH-1:0];
            buck_setpoint_pkg::MODE_SLEEP:
                next_setpointCode = sleepSetpointReg[buck_setpoint_pkg::CODE_WIDTH-1:0];
            default:
                next_setpointCode = normalSetpointReg[buck_setpoint_pkg::CODE_WIDTH-1:0];
        endcase
        next_phaseConfigValid = (phaseConfigField == buck_setpoint_pkg::PHASE_CONFIG_SINGLE);
        sharedFields.currentLimitLevel   = sharedConfigReg[buck_setpoint_pkg::ILIM_BIT];
        sharedFields.switchingFreqSelect = sharedConfigReg[buck_setpoint_pkg::FREQ_LSB +: 2];
        sharedFields.clockPhaseSelect    = sharedConfigReg[buck_setpoint_pkg::PHASE_LSB +: 2];
        sharedFields.rampSpeedSelect     = sharedConfigReg[buck_setpoint_pkg::SPEED_LSB +: 2];
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            setpointCode     <= '0;
            switchNodeA      <= '0;
            switchNodeB      <= '0;
            modeSelect       <= buck_setpoint_pkg::MODE_SELECT_RESET;
            phaseConfigValid <= 1'b1;
        end
        else
        begin
            setpointCode     <= next_setpointCode;
            // one register feeds both nodes, so they cannot disagree
            switchNodeA      <= sharedFields;
            switchNodeB      <= sharedFields;
            modeSelect       <= modeSelectReg;
            phaseConfigValid <= next_phaseConfigValid;
        end
    end

    // code maps to 0.300 V + 25 mV * code; the analog side decodes it
    ramp_stepper u_ramp
    (
        .ref_clk         (ref_clk),
        .rst             (rst),
        .setpointCode    (setpointCode),
        .rampSpeedSelect (sharedFields.rampSpeedSelect),
        .targetCode      (targetCode),
        .rampBusy        (rampBusy)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_unused_bits_zero: assert property (@(posedge ref_clk) disable iff (rst)
        regRead && regAddr inside {8'h20, 8'h21, 8'h22} |=> regReadData[7:6] == 2'h0)
        else $error("unused set-point bits read nonzero");

    // write, one idle cycle, then the read of the same register
    chk_normal_readback: assert property (@(posedge ref_clk) disable iff (rst)
        regWrite && regAddr == 8'h20 ##1 !regWrite && !regRead ##1
        regRead && regAddr == 8'h20 && !regWrite
        |=> regReadData == ($past(regWriteData, 3) & 8'h3F))
        else $error("normal set point readback wrong");

    chk_standby_select: assert property (@(posedge ref_clk) disable iff (rst)
        standby && !sleepMode |=> setpointCode == $past(standbySetpointReg[5:0]))
        else $error("standby code not selected");

    chk_normal_select: assert property (@(posedge ref_clk) disable iff (rst)
        !standby && !sleepMode |=> setpointCode == $past(normalSetpointReg[5:0]))
        else $error("normal code not selected");

    chk_sleep_select: assert property (@(posedge ref_clk) disable iff (rst)
        sleepMode |=> setpointCode == $past(sleepSetpointReg[5:0]))
        else $error("sleep code not selected");

    chk_nodes_match: assert property (@(posedge ref_clk) disable iff (rst)
        switchNodeA == switchNodeB)
        else $error("switch nodes disagree");

    chk_config_fields: assert property (@(posedge ref_clk) disable iff (rst)
        regWrite && regAddr == 8'h24 ##1 1'b1 |=>
        switchNodeA.rampSpeedSelect == $past(regWriteData[7:6], 2) &&
        switchNodeA.switchingFreqSelect == $past(regWriteData[3:2], 2))
        else $error("config fields misplaced");

    chk_phase_config: assert property (@(posedge ref_clk) disable iff (rst)
        otpLoad ##1 !otpLoad |=> phaseConfigValid == ($past(otpPhaseConfig, 2) == 2'h1))
        else $error("phase config acceptance wrong");

    chk_other_mode_held: assert property (@(posedge ref_clk) disable iff (rst)
        !standby && !sleepMode ##0 regWrite && regAddr == 8'h21 ##1
        !standby && !sleepMode && !regWrite |=> $stable(setpointCode))
        else $error("inactive mode write changed target");

    chk_read_answer: assert property (@(posedge ref_clk) disable iff (rst)
        regRead || extRead |=> regReadValid)
        else $error("read not answered in the next cycle");

    chk_read_single: assert property (@(posedge ref_clk) disable iff (rst)
        !regRead && !extRead |=> !regReadValid)
        else $error("read valid without a read");

    chk_unmapped_zero: assert property (@(posedge ref_clk) disable iff (rst)
        regRead && (regAddr < buck_setpoint_pkg::NORMAL_SETPOINT_ADDR ||
        regAddr > buck_setpoint_pkg::SHARED_CONFIG_ADDR) |=> regReadData == 8'h00)
        else $error("unmapped address read nonzero");

    chk_mode_unused: assert property (@(posedge ref_clk) disable iff (rst)
        regWrite && regAddr == buck_setpoint_pkg::MODE_SELECT_ADDR |=>
        ##1 modeSelect[7:6] == 2'h0 && modeSelect[4] == 1'b0)
        else $error("unused mode bits written");

    chk_ext_phase_read: assert property (@(posedge ref_clk) disable iff (rst)
        extRead && !regRead && extAddr == buck_setpoint_pkg::PHASE_CONFIG_ADDR |=>
        phaseConfigValid == (regReadData == 8'h01))
        else $error("extended page phase read wrong");

    chk_busy_apart: assert property (@(posedge ref_clk) disable iff (rst)
        targetCode != setpointCode |=> rampBusy)
        else $error("ramp idle while target differs");

    cov_standby_entry: cover property (@(posedge ref_clk) disable iff (rst) $rose(standby));
    cov_sleep_entry:   cover property (@(posedge ref_clk) disable iff (rst) $rose(sleepMode));
    cov_ramp_done:     cover property (@(posedge ref_clk) disable iff (rst) $fell(rampBusy));
    cov_ext_read:      cover property (@(posedge ref_clk) disable iff (rst) extRead);

endmodule

// ---- rtl/ramp_stepper.sv ----
/*
 * Steps a 6-bit target code toward a set-point code, one code per
 * interval chosen by the ramp speed field.
 * Assumes the set-point input may change at any cycle.
 */
`timescale 1ns/1ps
module ramp_stepper
(
    input  wire logic                                      ref_clk,
    input  wire logic                                      rst,
    input  wire logic [buck_setpoint_pkg::CODE_WIDTH-1:0]  setpointCode,
    input  wire logic [1:0]                                rampSpeedSelect,
    output logic      [buck_setpoint_pkg::CODE_WIDTH-1:0]  targetCode,
    output logic                                           rampBusy
);

    localparam int CW = buck_setpoint_pkg::STEP_COUNT_WIDTH;

    logic [CW-1:0]                               stepCount;
    logic [CW-1:0]                               next_stepCount;
    logic [buck_setpoint_pkg::CODE_WIDTH-1:0]    next_targetCode;
    logic                                        next_rampBusy;
    logic [CW-1:0]                               stepLimit;

    // interval doubles per speed code: 80, 160, 320, 640 cycles
    assign stepLimit = CW'(buck_setpoint_pkg::STEP_BASE_CYCLES) << rampSpeedSelect;

    always_comb
    begin
        next_stepCount  = stepCount;
        next_targetCode = targetCode;
        next_rampBusy   = (targetCode != setpointCode);
        if (targetCode == setpointCode)
        begin
            next_stepCount = '0;
        end
        else if (stepCount >= stepLimit - CW'(1))
        begin
            next_stepCount = '0;
            if (setpointCode > targetCode)
                next_targetCode = targetCode + 6'h01;
            else
                next_targetCode = targetCode - 6'h01;
        end
        else
        begin
            next_stepCount = stepCount + CW'(1);
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            stepCount  <= '0;
            targetCode <= '0;
            rampBusy   <= 1'b0;
        end
        else
        begin
            stepCount  <= next_stepCount;
            targetCode <= next_targetCode;
            rampBusy   <= next_rampBusy;
        end
    end

    chk_step_single_code: assert property (@(posedge ref_clk) disable iff (rst)
        targetCode != $past(targetCode) |->
        (targetCode - $past(targetCode) == 6'h01) ||
        ($past(targetCode) - targetCode == 6'h01))
        else $error("target moved by more than one code");

    chk_step_fast_spacing: assert property (@(posedge ref_clk) disable iff (rst)
        (rampSpeedSelect == 2'h0 && $changed(targetCode)) ##1
        (rampSpeedSelect == 2'h0) [*8] |-> $stable(targetCode))
        else $error("ramp steps closer than the interval");

endmodule
